// ---- hw/decoder_ctrl_device.sv ----
`timescale 1ns/1ps
`include "decoder_ctrl_consts.svh"
// Functional notes
// R1: Pixels leave at quarter system clock
// R2: Macroblocks leave in received order
// R3: One valid pulse per output pixel
// R4: Boundary signal spans each output macroblock
// R5: Frame ready follows first/last boundary
// R6: First pixel two clocks after boundary
// R7: Last two blocks wait for next picture
// R8: Host writes instruction, then data phase
// R9: Strobe taken only with select low
// R10: Unrelated transfers allowed while deselected
// R11: Read byte driven after access delay
// R12: Data line high before read strobe
// R13: Bus released on deselect or low address
// R14: Instruction decoded from low nibble only
// R15: Instruction code assignments
// R16: Setup bit0 quarter, bit6 big DRAM
// R17: Reset gives full CIF, small DRAM
// R18: Host keeps other setup bits low
// R19: Host resets on format change
// R20: Group read on low nibble
// R21: Block number with stability bit six
// R22: Decision flags inter, MC, filter, skip
// R23: No pixels while skip active
// R24: Unknown instructions have no effect
module decoder_ctrl_device
  import decoder_ctrl_pkg::*;
#(
  parameter int PIPE_DEPTH = 2,
  parameter int BLOCKS_FULL = `BLOCKS_CIF, // Blocks in a full picture
  parameter int BLOCKS_QUARTER = `BLOCKS_QCIF // Blocks in a quarter picture
) (
  input wire logic clk,
  input wire logic nrst,
  decoder_ctrl_if.device link,
  input wire logic blockIn, // One pulse per macroblock received
  input wire logic [3:0] blockGroupIn, // Group of received block
  input wire logic [5:0] blockIndexIn, // Number of received block
  input wire logic [7:0] blockFlagsIn, // Decisions of received block
  input wire logic [7:0] pixelIn, // Reconstructed pixel source
  output logic quarterModeOut, // Setup: quarter format
  output logic bigDramOut, // Setup: 256K-word DRAM
  output logic clkOverrideOut // Doubler override seen
);
  // Per-block side info carried through the pipeline
  typedef struct packed {
    logic [3:0] grp;
    logic [5:0] idx;
    logic [7:0] flg;
  } blk_info_t;

  typedef struct packed {
    logic [2:0] selSync; // Select pin synchroniser
    logic [2:0] adrSync; // Address pin synchroniser
    logic [2:0] strSync; // Strobe pin synchroniser
    logic [7:0] busCap; // Bus sample beside the strobe
    logic [7:0] busCapB;
    logic selN;
    logic adr;
    logic str;
    host_op_e op;
    logic [7:0] setup;
    logic clkOvr;
    logic [7:0] drvByte;
    logic drvOe;
    blk_info_t [1:0] pipe; // Two-deep macroblock pipeline
    logic [1:0] pipeCnt;
    blk_info_t cur; // Block now on output
    logic curStable;
    logic skip;
    pixel_state_e pst;
    logic [8:0] pixCnt;
    logic [1:0] phase;
    logic [8:0] frameBlk;
    logic [7:0] pixData;
    logic pixel_valid_strobe;
    logic mbo;
    logic frm;
  } dev_state_s;

  dev_state_s cur_ff, nxt_cur;

  // Block count of one picture in the active format
  function automatic logic [8:0] frameBlocks(input logic quarter);
    frameBlocks = quarter ? 9'(BLOCKS_QUARTER) : 9'(BLOCKS_FULL);
  endfunction

  // R15: instruction nibble to operation
  function automatic host_op_e decodeOp(input logic [3:0] code);
    case (code)
      `INSTR_LOAD_SETUP: decodeOp = OP_LOAD_SETUP;
      `INSTR_READ_GROUP: decodeOp = OP_READ_GROUP;
      `INSTR_READ_BLOCK: decodeOp = OP_READ_BLOCK;
      `INSTR_READ_FLAGS: decodeOp = OP_READ_FLAGS;
      `INSTR_READ_SETUP: decodeOp = OP_READ_SETUP;
      `INSTR_CLK_OVERRIDE: decodeOp = OP_CLK_OVERRIDE;
      default: decodeOp = OP_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic strRise;
    logic readSel;
    logic [7:0] rdVal;
    strRise = 1'b0;
    readSel = 1'b0;
    rdVal = 8'h00;
    nxt_cur = cur_ff;
    // Three-stage pin capture; change counts when stages 2 and 3 agree
    nxt_cur.selSync = {cur_ff.selSync[1:0], link.hostSelectN};
    nxt_cur.adrSync = {cur_ff.adrSync[1:0], link.instrDataSelect};
    nxt_cur.strSync = {cur_ff.strSync[1:0], link.hostTransferStrobe};
    nxt_cur.busCap = link.hostByteBus;
    nxt_cur.busCapB = cur_ff.busCap;
    if (cur_ff.selSync[1] == cur_ff.selSync[2]) begin
      nxt_cur.selN = cur_ff.selSync[2];
    end
    if (cur_ff.adrSync[1] == cur_ff.adrSync[2]) begin
      nxt_cur.adr = cur_ff.adrSync[2];
    end
    if (cur_ff.strSync[1] == cur_ff.strSync[2]) begin
      nxt_cur.str = cur_ff.strSync[2];
    end
    // R9 R10: strobe edge only while selected
    strRise = nxt_cur.str && !cur_ff.str && !cur_ff.selN;
    if (strRise && !cur_ff.adr) begin
      // R14: low nibble decides, R24 unknown codes do nothing
      nxt_cur.op = decodeOp(cur_ff.busCapB[3:0]);
      if (decodeOp(cur_ff.busCapB[3:0]) == OP_CLK_OVERRIDE) begin
        nxt_cur.clkOvr = 1'b1;
      end
    end else if (strRise && cur_ff.adr && cur_ff.op == OP_LOAD_SETUP) begin
      // R16: only format and memory selects are kept
      nxt_cur.setup = cur_ff.busCapB & `SETUP_WRITE_MASK;
    end
    // R20 R21 R22: read data sources
    case (cur_ff.op)
      OP_READ_GROUP: rdVal = {4'h0, cur_ff.cur.grp};
      OP_READ_BLOCK: rdVal = {1'b0, cur_ff.curStable, cur_ff.cur.idx};
      OP_READ_FLAGS: begin
        rdVal = 8'h00;
        rdVal[`FLAG_INTER_BIT] = cur_ff.cur.flg[`FLAG_INTER_BIT];
        rdVal[`FLAG_MC_BIT] = cur_ff.cur.flg[`FLAG_MC_BIT];
        rdVal[`FLAG_FILTER_BIT] = cur_ff.cur.flg[`FLAG_FILTER_BIT];
        rdVal[`FLAG_SKIP_BIT] = cur_ff.skip;
      end
      OP_READ_SETUP: rdVal = cur_ff.setup;
      default: rdVal = 8'h00;
    endcase
    readSel = (cur_ff.op == OP_READ_GROUP) || (cur_ff.op == OP_READ_BLOCK) ||
              (cur_ff.op == OP_READ_FLAGS) || (cur_ff.op == OP_READ_SETUP);
    // R11 R13: drive while selected with address high, else release
    nxt_cur.drvOe = readSel && !cur_ff.selN && cur_ff.adr;
    nxt_cur.drvByte = rdVal;
    // R2 R7: received blocks queue two deep before output
    if (blockIn) begin
      nxt_cur.skip = blockFlagsIn[`FLAG_SKIP_BIT];
      if (blockFlagsIn[`FLAG_SKIP_BIT]) begin
        // R23: skip flushes the pipeline, no output
        nxt_cur.pipeCnt = 2'd0;
        nxt_cur.frameBlk = 9'd0;
      end else begin
        nxt_cur.pipe[1] = cur_ff.pipe[0];
        nxt_cur.pipe[0] = {blockGroupIn, blockIndexIn, blockFlagsIn};
        if (cur_ff.pipeCnt < 2'(PIPE_DEPTH)) begin
          nxt_cur.pipeCnt = cur_ff.pipeCnt + 2'd1;
        end else if (cur_ff.pst == PX_IDLE) begin
          // Oldest block leaves; the next received block pushes it out
          nxt_cur.cur = cur_ff.pipe[1];
          nxt_cur.curStable = 1'b0;
          nxt_cur.pst = PX_LEAD;
          // First pixel settles two clocks ahead of its strobe
          nxt_cur.pixData = pixelIn;
          nxt_cur.phase = 2'd0;
          // R4: boundary rises with the block
          nxt_cur.mbo = 1'b1;
          // R5: frame ready rises with first boundary
          if (cur_ff.frameBlk == 9'd0) begin
            nxt_cur.frm = 1'b1;
          end
        end
      end
    end
    // Pixel sequencer
    nxt_cur.pixel_valid_strobe = 1'b0;
    case (cur_ff.pst)
      PX_IDLE: begin
      end
      PX_LEAD: begin
        // R6: first strobe two clocks after boundary; phase runs on
        nxt_cur.phase = cur_ff.phase + 2'd1;
        if (cur_ff.phase == 2'(`PIXEL_LEAD_CYCLES - 1)) begin
          nxt_cur.pst = PX_PIXELS;
          nxt_cur.pixCnt = 9'd0;
          nxt_cur.curStable = 1'b1;
          nxt_cur.pixel_valid_strobe = !cur_ff.skip;
        end
      end
      PX_PIXELS: begin
        // R1 R3: one strobe every fourth clock; data changes two
        // clocks before and two clocks after each strobe edge
        nxt_cur.phase = cur_ff.phase + 2'd1;
        if (cur_ff.phase == 2'(`PIXEL_LEAD_CYCLES - 1)) begin
          nxt_cur.pixel_valid_strobe = !cur_ff.skip;
        end
        if (cur_ff.phase == 2'(`PIXEL_DIVIDE - 1)) begin
          nxt_cur.pixData = pixelIn;
          nxt_cur.pixCnt = cur_ff.pixCnt + 9'd1;
          if (cur_ff.pixCnt == 9'(`PIXELS_PER_BLOCK - 1)) begin
            nxt_cur.pst = PX_GAP;
            nxt_cur.mbo = 1'b0;
            nxt_cur.curStable = 1'b0;
            nxt_cur.frameBlk = cur_ff.frameBlk + 9'd1;
            // R5: frame ready falls with last boundary
            if (cur_ff.frameBlk == frameBlocks(cur_ff.setup[0]) - 9'd1) begin
              nxt_cur.frm = 1'b0;
              nxt_cur.frameBlk = 9'd0;
            end
          end
        end
      end
      PX_GAP: begin
        nxt_cur.pst = PX_IDLE;
      end
      default: nxt_cur.pst = PX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // R17: full CIF, small DRAM after reset
      cur_ff <= '{selSync: 3'h7, selN: 1'b1, setup: `SETUP_RESET,
                  op: OP_NONE, pst: PX_IDLE, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs come straight from state flops
  assign link.devByteOut = cur_ff.drvByte;
  assign link.devByteOe = cur_ff.drvOe;
  assign link.pixelData = cur_ff.pixData;
  assign link.pixelValidStrobe = cur_ff.pixel_valid_strobe;
  assign link.blockBoundaryOut = cur_ff.mbo;
  assign link.frameReadyOut = cur_ff.frm;
  assign quarterModeOut = cur_ff.setup[`SETUP_QUARTER_BIT];
  assign bigDramOut = cur_ff.setup[`SETUP_BIGDRAM_BIT];
  assign clkOverrideOut = cur_ff.clkOvr;
endmodule

// ---- common/decoder_ctrl_consts.svh ----
`ifndef DECODER_CTRL_CONSTS_SVH
`define DECODER_CTRL_CONSTS_SVH
// Instruction codes, low nibble of the host byte
`define INSTR_LOAD_SETUP 4'h4
`define INSTR_READ_GROUP 4'h8
`define INSTR_READ_BLOCK 4'h9
`define INSTR_READ_FLAGS 4'hb
`define INSTR_READ_SETUP 4'hc
`define INSTR_CLK_OVERRIDE 4'hf
// Setup byte fields
`define SETUP_QUARTER_BIT 0
`define SETUP_BIGDRAM_BIT 6
`define SETUP_WRITE_MASK 8'h41
`define SETUP_RESET 8'h00
// Block number byte fields
`define BLOCK_STABLE_BIT 6
// Decision flag fields
`define FLAG_INTER_BIT 0
`define FLAG_MC_BIT 1
`define FLAG_FILTER_BIT 3
`define FLAG_SKIP_BIT 6
// Pixel timing
`define SYS_CLK_MHZ 20
`define PIXEL_DIVIDE 4
`define PIXEL_LEAD_CYCLES 2
`define PIXELS_PER_BLOCK 384
`define BLOCKS_CIF 396
`define BLOCKS_QCIF 99
`define BLOCK_GAP_CYCLES 4
`endif

// ---- common/decoder_ctrl_pkg.sv ----
package decoder_ctrl_pkg;
  // Decoded instruction class held between phases
  typedef enum logic [2:0] {
    OP_NONE, OP_LOAD_SETUP, OP_READ_GROUP, OP_READ_BLOCK, OP_READ_FLAGS,
    OP_READ_SETUP, OP_CLK_OVERRIDE
  } host_op_e;
  // Pixel output sequencer states
  typedef enum logic [1:0] {
    PX_IDLE, PX_LEAD, PX_PIXELS, PX_GAP
  } pixel_state_e;
  // Host sequencer states
  typedef enum logic [2:0] {
    HS_IDLE, HS_INSTR, HS_WAIT, HS_DATA_WR, HS_DATA_RD, HS_DONE
  } host_state_e;
endpackage

// ---- common/decoder_ctrl_if.sv ----
`timescale 1ns/1ps
interface decoder_ctrl_if;
  logic hostSelectN; // Chip enable, low active
  logic instrDataSelect; // Low: instruction, high: data
  logic hostTransferStrobe; // Capture on rising edge
  logic [7:0] hostByteOut; // Host drive value
  logic hostByteOe; // Host drives the bus
  logic [7:0] devByteOut; // Device drive value
  logic devByteOe; // Device drives the bus
  logic [7:0] hostByteBus; // Resolved bus level
  logic [7:0] pixelData; // Decoded pixel
  logic pixelValidStrobe; // One pulse per pixel
  logic blockBoundaryOut; // High across a macroblock
  logic frameReadyOut; // High across a frame
  // Wire resolution; undriven bus floats high
  assign hostByteBus = hostByteOe ? hostByteOut :
                       (devByteOe ? devByteOut : 8'hff);
  modport device (
    input hostSelectN, instrDataSelect, hostTransferStrobe, hostByteBus,
    output devByteOut, devByteOe, pixelData, pixelValidStrobe,
    blockBoundaryOut, frameReadyOut
  );
  modport host (
    output hostSelectN, instrDataSelect, hostTransferStrobe, hostByteOut,
    hostByteOe,
    input hostByteBus, pixelData, pixelValidStrobe, blockBoundaryOut,
    frameReadyOut
  );
endinterface

// ---- hw/decoder_ctrl_host.sv ----
`timescale 1ns/1ps
`include "decoder_ctrl_consts.svh"
module decoder_ctrl_host
  import decoder_ctrl_pkg::*;
#(
  parameter int PHASE_CYCLES = 6 // Clocks per bus phase step
) (
  input wire logic clk,
  input wire logic nrst,
  decoder_ctrl_if.host link,
  input wire logic reqValid, // One-cycle command pulse
  input wire logic reqWrite, // Data phase writes
  input wire logic [3:0] reqInstr, // Instruction code
  input wire logic [7:0] reqData, // Write data
  output logic busy, // Transfer running
  output logic doneStrobe, // One pulse at the end
  output logic [7:0] readData // Last read byte
);
  typedef struct packed {
    host_state_e st;
    logic [3:0] cnt;
    logic wr;
    logic [7:0] instr;
    logic [7:0] data;
    logic selN;
    logic adr;
    logic str;
    logic [7:0] bus;
    logic oe;
    logic bsy;
    logic done;
    logic [7:0] rd;
  } host_state_s;

  host_state_s cur_ff, nxt_cur;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: select, set address, raise strobe, release
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.cnt = cur_ff.cnt + 4'd1;
    case (cur_ff.st)
      HS_IDLE: begin
        nxt_cur.cnt = 4'd0;
        if (reqValid) begin
          // R14 R18: upper bits held low
          nxt_cur.instr = {4'h0, reqInstr};
          nxt_cur.data = reqData & `SETUP_WRITE_MASK;
          nxt_cur.wr = reqWrite;
          nxt_cur.bsy = 1'b1;
          nxt_cur.st = HS_INSTR;
          nxt_cur.selN = 1'b0;
          nxt_cur.adr = 1'b0;
          nxt_cur.bus = {4'h0, reqInstr};
          nxt_cur.oe = 1'b1;
        end
      end
      HS_INSTR: begin
        // R8: instruction with address low, strobe mid phase
        nxt_cur.str = (cur_ff.cnt >= 4'(PHASE_CYCLES / 3)) &&
                      (cur_ff.cnt < 4'(2 * PHASE_CYCLES / 3));
        if (cur_ff.cnt == 4'(PHASE_CYCLES - 1)) begin
          nxt_cur.st = HS_WAIT;
          nxt_cur.cnt = 4'd0;
          nxt_cur.selN = 1'b1;
          nxt_cur.oe = 1'b0;
        end
      end
      HS_WAIT: begin
        // R10 R12: address high before select and strobe
        nxt_cur.adr = 1'b1;
        if (cur_ff.cnt == 4'(PHASE_CYCLES - 1)) begin
          nxt_cur.cnt = 4'd0;
          nxt_cur.selN = 1'b0;
          nxt_cur.st = cur_ff.wr ? HS_DATA_WR : HS_DATA_RD;
          nxt_cur.oe = cur_ff.wr;
          nxt_cur.bus = cur_ff.data;
        end
      end
      HS_DATA_WR, HS_DATA_RD: begin
        nxt_cur.str = (cur_ff.cnt >= 4'(PHASE_CYCLES / 3)) &&
                      (cur_ff.cnt < 4'(2 * PHASE_CYCLES / 3));
        if (cur_ff.cnt == 4'(PHASE_CYCLES - 1)) begin
          if (cur_ff.st == HS_DATA_RD) begin
            nxt_cur.rd = link.hostByteBus;
          end
          nxt_cur.st = HS_DONE;
          nxt_cur.cnt = 4'd0;
          nxt_cur.selN = 1'b1;
          nxt_cur.oe = 1'b0;
        end
      end
      HS_DONE: begin
        // R13: sit out the device's filtered bus release, so the next
        // instruction never drives against a read byte still on the bus
        nxt_cur.adr = 1'b0;
        if (cur_ff.cnt == 4'(PHASE_CYCLES - 1)) begin
          nxt_cur.bsy = 1'b0;
          nxt_cur.done = 1'b1;
          nxt_cur.st = HS_IDLE;
        end
      end
      default: nxt_cur.st = HS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '{st: HS_IDLE, selN: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.hostSelectN = cur_ff.selN;
  assign link.instrDataSelect = cur_ff.adr;
  assign link.hostTransferStrobe = cur_ff.str;
  assign link.hostByteOut = cur_ff.bus;
  assign link.hostByteOe = cur_ff.oe;
  assign busy = cur_ff.bsy;
  assign doneStrobe = cur_ff.done;
  assign readData = cur_ff.rd;
endmodule

// ---- verif/decoder_ctrl_assertions.sv ----
`timescale 1ns/1ps
module decoder_ctrl_assertions
  import decoder_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hostSelectN, // Chip enable, low active
  input wire logic instrDataSelect, // Instruction or data phase
  input wire logic hostTransferStrobe, // Host capture strobe
  input wire logic [7:0] hostByteOut, // Host drive value
  input wire logic hostByteOe, // Host owns the bus
  input wire logic devByteOe, // Device owns the bus
  input wire logic [7:0] pixelData, // Pixel on the pins
  input wire logic pixelValidStrobe, // Pixel strobe
  input wire logic blockBoundaryOut, // Block span
  input wire logic frameReadyOut // Frame span
);
  // Single clock domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  // Pixel port
  AST_PIX_RATE:
    assert property (pixelValidStrobe |=> !pixelValidStrobe [*3])
    else $error("pixel strobe faster than quarter clock");
  AST_PIX_IN_BLOCK:
    assert property (pixelValidStrobe |-> blockBoundaryOut)
    else $error("pixel strobe outside a block");
  AST_FIRST_LEAD:
    assert property ($rose(blockBoundaryOut) |->
      !pixelValidStrobe ##1 !pixelValidStrobe ##1 pixelValidStrobe)
    else $error("first pixel not two clocks after boundary");
  AST_DATA_HOLD:
    assert property (pixelValidStrobe |-> $stable(pixelData) &&
      pixelData == $past(pixelData, 2) ##1 $stable(pixelData))
    else $error("pixel data moved around its strobe");
  AST_FRAME_RISE:
    assert property ($rose(frameReadyOut) |-> $rose(blockBoundaryOut))
    else $error("frame ready rose without a boundary");
  AST_FRAME_FALL:
    assert property ($fell(frameReadyOut) |-> $fell(blockBoundaryOut))
    else $error("frame ready fell without a boundary");
  AST_FRAME_COVERS:
    assert property (blockBoundaryOut |-> frameReadyOut)
    else $error("block output outside a frame");
  //////////////////////////////////////////////////////////////////////////
  // Host byte bus; release allows for the input filter
  AST_BUS_RELEASE:
    assert property ((hostSelectN || !instrDataSelect) [*6] |-> !devByteOe)
    else $error("device still drives a released bus");
  AST_NO_CLASH:
    assert property (devByteOe |-> !hostByteOe)
    else $error("both ends drive the bus");
  AST_INSTR_NIBBLE:
    assert property ($rose(hostTransferStrobe) && !hostSelectN &&
      !instrDataSelect |-> hostByteOe && hostByteOut[7:4] == 4'h0)
    else $error("instruction not written with upper bits low");
  AST_READ_ADDR:
    assert property ($rose(hostTransferStrobe) && !hostSelectN &&
      !hostByteOe |-> $past(instrDataSelect))
    else $error("read strobe before address high");
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "decoder_ctrl_consts.svh"
module tb
  import decoder_ctrl_pkg::*;
;
  logic clk, nrst, reqValid, reqWrite, busy, doneStrobe, blockIn;
  logic [3:0] reqInstr, blockGroupIn;
  logic [7:0] reqData, readData, blockFlagsIn, pixelIn;
  logic [5:0] blockIndexIn;
  logic quarterModeOut, bigDramOut, clkOverrideOut;
  int numErrors, checks, pixCount; // Verdict counters
  // Blocks in arrival order; the last one announces a skipped picture
  logic [3:0] grp [5] = '{4'h3, 4'h7, 4'h9, 4'h2, 4'h0};
  logic [5:0] idx [5] = '{6'h05, 6'h2a, 6'h11, 6'h3f, 6'h00};
  logic [7:0] flg [5] = '{8'h0b, 8'h08, 8'h03, 8'h00, 8'h40};
  logic [3:0] bad [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
                           4'ha, 4'hd, 4'he}; // Unused codes
  logic [7:0] setups [3] = '{8'h01, 8'h40, 8'h41};
  decoder_ctrl_if link();
  // Two-block quarter picture, so frame ready also falls within the run
  decoder_ctrl_device #(
    .BLOCKS_QUARTER(2)
  ) decoder_ctrl_device_i (.clk(clk), .nrst(nrst),
    .link(link), .blockIn(blockIn), .blockGroupIn(blockGroupIn),
    .blockIndexIn(blockIndexIn), .blockFlagsIn(blockFlagsIn),
    .pixelIn(pixelIn), .quarterModeOut(quarterModeOut),
    .bigDramOut(bigDramOut), .clkOverrideOut(clkOverrideOut));
  decoder_ctrl_host decoder_ctrl_host_i (.clk(clk), .nrst(nrst),
    .link(link), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqInstr(reqInstr), .reqData(reqData), .busy(busy),
    .doneStrobe(doneStrobe), .readData(readData));
  decoder_ctrl_assertions decoder_ctrl_assertions_i (.clk(clk),
    .nrst(nrst), .hostSelectN(link.hostSelectN),
    .instrDataSelect(link.instrDataSelect),
    .hostTransferStrobe(link.hostTransferStrobe),
    .hostByteOut(link.hostByteOut), .hostByteOe(link.hostByteOe),
    .devByteOe(link.devByteOe), .pixelData(link.pixelData),
    .pixelValidStrobe(link.pixelValidStrobe),
    .blockBoundaryOut(link.blockBoundaryOut),
    .frameReadyOut(link.frameReadyOut));
  //////////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic closeOut();
    if (numErrors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One two-phase host transfer; bounded wait on completion
  task automatic xfer(input logic wr, input logic [3:0] ins,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqInstr <= ins;
    reqData <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    check(busy, 1'b1);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (doneStrobe !== 1'b1 && n < 300);
    if (n >= 300) begin
      numErrors++;
      closeOut();
    end
    check(busy, 1'b0);
  endtask
  // One received block, announced by a single pulse
  task automatic sendBlock(input int k);
    @(posedge clk);
    blockIn <= 1'b1;
    blockGroupIn <= grp[k];
    blockIndexIn <= idx[k];
    blockFlagsIn <= flg[k];
    @(posedge clk);
    blockIn <= 1'b0;
  endtask
  // Count strobes across one block span
  task automatic countBlock();
    int n;
    n = 0;
    pixCount = 0;
    while (link.blockBoundaryOut !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      numErrors++;
      closeOut();
    end
    check(link.frameReadyOut, 1'b1);
    while (link.blockBoundaryOut === 1'b1 && n < 3000) begin
      if (link.pixelValidStrobe === 1'b1) pixCount++;
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      numErrors++;
      closeOut();
    end
    check(pixCount[15:0], 16'(`PIXELS_PER_BLOCK));
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pixel source keeps moving so stale data shows
  always @(posedge clk) begin
    if (!nrst) begin
      pixelIn <= 8'h00;
    end else begin
      pixelIn <= pixelIn + 8'h01;
    end
  end
  // Main sequence
  initial begin
    {nrst, reqValid, reqWrite, blockIn} = 4'h0;
    {reqInstr, blockGroupIn, blockIndexIn} = 14'h0;
    {reqData, blockFlagsIn} = 16'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    check({bigDramOut, quarterModeOut}, 2'h0);
    xfer(1'b0, `INSTR_READ_SETUP, 8'h00);
    check(readData, `SETUP_RESET);
    foreach (setups[i]) begin
      xfer(1'b1, `INSTR_LOAD_SETUP, setups[i]);
      xfer(1'b0, `INSTR_READ_SETUP, 8'h00);
      check(readData, setups[i]);
      check({bigDramOut, quarterModeOut}, {setups[i][6], setups[i][0]});
    end
    // Unused codes must leave setup alone
    foreach (bad[i]) xfer(1'b1, bad[i], 8'h00);
    xfer(1'b0, `INSTR_READ_SETUP, 8'h00);
    check(readData, 8'h41);
    xfer(1'b0, 4'h5, 8'h00);
    check(readData, 8'hff);
    check(clkOverrideOut, 1'b0);
    xfer(1'b1, `INSTR_CLK_OVERRIDE, 8'h00);
    check(clkOverrideOut, 1'b1);
    // Two blocks fill the pipeline; each later one releases the oldest
    sendBlock(0);
    sendBlock(1);
    for (int k = 0; k < 2; k++) begin
      fork
        countBlock();
        begin
          sendBlock(k + 2);
          repeat (50) @(posedge clk);
          xfer(1'b0, `INSTR_READ_GROUP, 8'h00);
          check(readData, {4'h0, grp[k]});
          xfer(1'b0, `INSTR_READ_BLOCK, 8'h00);
          check(readData, {2'b01, idx[k]});
          xfer(1'b0, `INSTR_READ_FLAGS, 8'h00);
          check(readData, flg[k] & 8'h0b);
        end
      join
      repeat (600) @(posedge clk);
    end
    // Two-block test picture is complete, so frame ready is down
    check(link.frameReadyOut, 1'b0);
    // Skip block flushes the queue and shows in the flags
    sendBlock(4);
    repeat (10) @(posedge clk);
    #1;
    check(link.blockBoundaryOut, 1'b0);
    xfer(1'b0, `INSTR_READ_FLAGS, 8'h00);
    check(readData, (flg[1] & 8'h0b) | 8'h40);
    // Back to full format, big memory, after blocks were taken
    xfer(1'b1, `INSTR_LOAD_SETUP, 8'h40);
    check({bigDramOut, quarterModeOut}, 2'h2);
    // format changed after blocks, so the device is reset
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check({bigDramOut, quarterModeOut}, 2'h0);
    xfer(1'b0, `INSTR_READ_SETUP, 8'h00);
    check(readData, `SETUP_RESET);
    closeOut();
  end
endmodule
